//--- eeprom_ctrl.sv
// controller end: register-driven serial master, mode 0
module eeprom_ctrl #(
  parameter int unsigned SCK_HALF = eeprom_pkg::SCK_HALF
) (
  // system
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // register port
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // serial link
  spi_if.ctrl bus
);
  typedef enum logic [1:0] {C_IDLE = 2'b00, C_LOW = 2'b01, C_HIGH = 2'b11, C_DONE = 2'b10} ctl_state_e;
  ctl_state_e state_q;
  logic [7:0] tx_q, rx_q;
  logic [2:0] bit_q;
  logic [7:0] div_q;
  logic cs_n_q, sck_q, mosi_q, hold_n_q, wp_n_q, end_q, done_q;
  logic miso_s;

  pin_sync #(.INIT(1'b0)) u_so (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_pin(bus.miso), .o_level(miso_s));

  ////////////////////////////////////////////////////////////
  // register writes and byte engine; one byte per start
  // select stays low across bytes until end bit given
  // clock idles low, sampled on rising edge
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      state_q <= C_IDLE;
      cs_n_q <= 1'b1;
      sck_q <= 1'b0;
      mosi_q <= 1'b0;
      hold_n_q <= 1'b1;
      wp_n_q <= 1'b1;
      end_q <= 1'b0;
      done_q <= 1'b0;
      tx_q <= 8'h00;
      rx_q <= 8'h00;
      bit_q <= 3'h0;
      div_q <= 8'h00;
    end else begin
      if (i_wr && i_addr == eeprom_pkg::REG_TXD) begin
        tx_q <= i_wdata[7:0];
      end
      // suspend only changes while clock is low, never on the edge that raises it
      if (i_wr && i_addr == eeprom_pkg::REG_CTRL && !sck_q &&
          !(state_q == C_LOW && div_q == 8'(SCK_HALF - 1))) begin
        hold_n_q <= !i_wdata[eeprom_pkg::CTRL_HOLD];
        wp_n_q <= !i_wdata[eeprom_pkg::CTRL_WP];
      end
      unique case (state_q)
        C_IDLE: begin
          if (i_wr && i_addr == eeprom_pkg::REG_CTRL && i_wdata[eeprom_pkg::CTRL_START]) begin
            cs_n_q <= 1'b0;
            end_q <= i_wdata[eeprom_pkg::CTRL_END];
            done_q <= 1'b0;
            bit_q <= 3'h0;
            div_q <= 8'h00;
            mosi_q <= tx_q[7];
            state_q <= C_LOW;
          end
        end
        C_LOW: begin
          if (hold_n_q) begin
            div_q <= div_q + 8'h1;
            if (div_q == 8'(SCK_HALF - 1)) begin
              div_q <= 8'h00;
              sck_q <= 1'b1;
              rx_q <= {rx_q[6:0], miso_s};
              state_q <= C_HIGH;
            end
          end
        end
        C_HIGH: begin
          div_q <= div_q + 8'h1;
          if (div_q == 8'(SCK_HALF - 1)) begin
            div_q <= 8'h00;
            sck_q <= 1'b0;
            bit_q <= bit_q + 3'h1;
            mosi_q <= tx_q[3'h6 - bit_q];
            state_q <= (bit_q == 3'h7) ? C_DONE : C_LOW;
          end
        end
        C_DONE: begin
          // with the end bit set, select rises before any further rising edge
          if (end_q) begin
            cs_n_q <= 1'b1;
          end
          done_q <= 1'b1;
          state_q <= C_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////
  // register read port, data one cycle after strobe
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_rdata <= 32'h0;
    end else if (i_rd) begin
      unique case (i_addr)
        eeprom_pkg::REG_STAT: o_rdata <= {30'h0, done_q, state_q != C_IDLE};
        eeprom_pkg::REG_RXD: o_rdata <= {24'h0, rx_q};
        eeprom_pkg::REG_TXD: o_rdata <= {24'h0, tx_q};
        eeprom_pkg::REG_CTRL: o_rdata <= {28'h0, end_q, !wp_n_q, !hold_n_q, 1'b0};
        default: o_rdata <= 32'h0;
      endcase
    end else begin
      o_rdata <= 32'h0;
    end
  end

  assign bus.cs_n = cs_n_q;
  assign bus.sck = sck_q;
  assign bus.mosi = mosi_q;
  assign bus.suspend_n = hold_n_q;
  assign bus.write_protect_n = wp_n_q;
endmodule

//--- eeprom_dev.sv
// memory device end: serial front end, status, array and write timer
//
// Added by the designer: strobed register access and the register addresses.
module eeprom_dev #(
  parameter int unsigned WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES
) (
  // system
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // supply monitor, low when supply under threshold
  input wire logic i_supply_ok,
  // serial link
  spi_if.dev bus,
  // status view
  output logic o_busy
);
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_OP = 3'b001, S_ADDR = 3'b011, S_DATA = 3'b010, S_SKIP = 3'b110
  } dev_state_e;
  logic cs_n_s, sck_s, mosi_s, susp_n_s, wp_n_s;
  logic sck_d1_q;
  dev_state_e state_q;
  logic [7:0] mem_q [eeprom_pkg::DEPTH];
  logic [7:0] page_q [2**eeprom_pkg::PAGE_W];
  logic [2**eeprom_pkg::PAGE_W-1:0] page_vld_q;
  logic [7:0] shift_q, op_q, out_q;
  logic [2:0] bit_q;
  logic addr_hi_q;
  logic [15:0] addr_q;
  logic [eeprom_pkg::ADDR_W-1:0] wr_base_q;
  logic latch_q, prot_en_q;
  logic [2:0] bp_q;
  logic [7:0] pend_stat_q;
  logic pend_stat_vld_q, pend_page_q;
  logic [31:0] timer_q;
  logic busy_q;
  logic miso_q, miso_oe_q;
  logic alive, rise, fall;
  logic [7:0] byte_in;
  logic [7:0] status;

  pin_sync #(.INIT(1'b1)) u_cs (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_pin(bus.cs_n), .o_level(cs_n_s));
  pin_sync #(.INIT(1'b0)) u_sck (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_pin(bus.sck), .o_level(sck_s));
  pin_sync #(.INIT(1'b0)) u_si (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_pin(bus.mosi), .o_level(mosi_s));
  pin_sync #(.INIT(1'b1)) u_hd (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_pin(bus.suspend_n), .o_level(susp_n_s));
  pin_sync #(.INIT(1'b1)) u_wp (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
    .i_pin(bus.write_protect_n), .o_level(wp_n_s));

  // reset and supply loss both hold everything idle
  assign alive = i_rstn && i_supply_ok;
  // clock edges while suspended are not seen; tied high never gates
  assign rise = sck_s && !sck_d1_q && susp_n_s && !cs_n_s;
  assign fall = !sck_s && sck_d1_q && susp_n_s && !cs_n_s;
  assign byte_in = {shift_q[6:0], mosi_s};
  // all ones while the internal write runs
  assign status = busy_q ? 8'hff : {prot_en_q, 2'b00, bp_q, latch_q, 1'b0};

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      sck_d1_q <= 1'b0;
    end else begin
      sck_d1_q <= sck_s;
    end
  end

  ////////////////////////////////////////////////////////////
  // serial front end
  // supply loss abandons the transfer and collected page
  always_ff @(posedge i_sys_clk) begin
    if (!alive || cs_n_s) begin
      state_q <= S_IDLE;
      bit_q <= 3'h0;
      shift_q <= 8'h00;
      addr_hi_q <= 1'b0;
      if (!alive) begin
        op_q <= 8'h00;
        addr_q <= 16'h0000;
      end
    end else begin
      if (state_q == S_IDLE) begin
        state_q <= S_OP;
      end
      if (rise) begin
        shift_q <= byte_in;
        bit_q <= bit_q + 3'h1;
        if (bit_q == 3'h7) begin
          unique case (state_q)
            S_OP: begin
              op_q <= byte_in & eeprom_pkg::CODE_MASK;
              // a busy device takes only the status read
              if (busy_q && (byte_in & eeprom_pkg::CODE_MASK) != eeprom_pkg::READ_STATUS_CMD) begin
                state_q <= S_SKIP;
              end else if ((byte_in & eeprom_pkg::CODE_MASK) == eeprom_pkg::READ_ARRAY_CMD ||
                           (byte_in & eeprom_pkg::CODE_MASK) == eeprom_pkg::WRITE_ARRAY_CMD) begin
                state_q <= S_ADDR;
              end else begin
                state_q <= S_DATA;
              end
            end
            S_ADDR: begin
              addr_hi_q <= 1'b1;
              if (!addr_hi_q) begin
                addr_q[15:8] <= byte_in;
              end else begin
                addr_q[7:0] <= byte_in;
                state_q <= S_DATA;
              end
            end
            S_DATA: begin
              // read address wraps from last to zero
              if (op_q == eeprom_pkg::READ_ARRAY_CMD) begin
                addr_q[14:0] <= addr_q[14:0] + 15'h1;
              end
              // write address wraps inside the page
              if (op_q == eeprom_pkg::WRITE_ARRAY_CMD) begin
                addr_q[6:0] <= addr_q[6:0] + 7'h1;
              end
            end
            S_SKIP: begin
            end
            default: state_q <= S_SKIP;
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // write collection, latch and status register
  always_ff @(posedge i_sys_clk) begin
    if (!alive) begin
      latch_q <= 1'b0;
      page_vld_q <= '0;
      pend_page_q <= 1'b0;
      pend_stat_vld_q <= 1'b0;
      pend_stat_q <= 8'h00;
      wr_base_q <= '0;
      if (!i_rstn) begin
        bp_q <= 3'h0;
        prot_en_q <= 1'b0;
      end
    end else if (rise && bit_q == 3'h7 && state_q == S_DATA && latch_q && !busy_q) begin
      // only bytes that arrive are marked for programming
      if (op_q == eeprom_pkg::WRITE_ARRAY_CMD && bp_q[1:0] != 2'b11) begin
        page_q[addr_q[6:0]] <= byte_in;
        page_vld_q[addr_q[6:0]] <= 1'b1;
        wr_base_q <= addr_q[14:0];
        pend_page_q <= 1'b1;
      end
      if (op_q == eeprom_pkg::WRITE_STATUS_CMD) begin
        pend_stat_q <= byte_in;
        pend_stat_vld_q <= 1'b1;
      end
    end else if (rise && bit_q == 3'h7 && state_q == S_OP && !busy_q) begin
      if ((byte_in & eeprom_pkg::CODE_MASK) == eeprom_pkg::SET_WRITE_LATCH_CMD) begin
        latch_q <= 1'b1;
      end
      if ((byte_in & eeprom_pkg::CODE_MASK) == eeprom_pkg::CLEAR_WRITE_LATCH_CMD) begin
        latch_q <= 1'b0;
      end
    end else if (cs_n_s && (pend_stat_vld_q || pend_page_q ||
                 (state_q != S_IDLE && (op_q == eeprom_pkg::WRITE_STATUS_CMD ||
                  op_q == eeprom_pkg::WRITE_ARRAY_CMD)))) begin
      // status or array write clears the latch
      latch_q <= 1'b0;
      pend_stat_vld_q <= 1'b0;
      if (pend_stat_vld_q && !(!wp_n_s && prot_en_q)) begin
        bp_q <= pend_stat_q[eeprom_pkg::ST_BP_HI:eeprom_pkg::ST_BP_LO];
        prot_en_q <= pend_stat_q[eeprom_pkg::ST_PROT_EN];
      end
      if (pend_page_q) begin
        for (int i = 0; i < 2**eeprom_pkg::PAGE_W; i++) begin
          if (page_vld_q[i]) begin
            mem_q[{wr_base_q[14:7], i[6:0]}] <= page_q[i];
          end
        end
        page_vld_q <= '0;
        pend_page_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // self-timed write cycle
  // busy for the programming time, then standby
  always_ff @(posedge i_sys_clk) begin
    if (!alive) begin
      busy_q <= 1'b0;
      timer_q <= 32'h0;
    end else if (cs_n_s && (pend_stat_vld_q || pend_page_q)) begin
      busy_q <= 1'b1;
      timer_q <= 32'(WRITE_CYCLES - 1);
    end else if (busy_q) begin
      if (timer_q == 32'h0) begin
        busy_q <= 1'b0;
      end else begin
        timer_q <= timer_q - 32'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // output driver
  // output released when deselected or idle
  always_ff @(posedge i_sys_clk) begin
    if (!alive || cs_n_s) begin
      miso_q <= 1'b0;
      miso_oe_q <= 1'b0;
      out_q <= 8'h00;
    end else if (rise && bit_q == 3'h7 && state_q == S_ADDR) begin
      // first read byte: the low address byte is only complete at this edge
      out_q <= mem_q[{addr_q[14:8], byte_in}];
    end else if (rise && bit_q == 3'h7 && state_q != S_OP) begin
      // next byte to send; the address counter still points at the byte just sent
      out_q <= (op_q == eeprom_pkg::READ_STATUS_CMD) ? status : mem_q[addr_q[14:0] + 15'h1];
    end else if (rise && bit_q == 3'h7 && state_q == S_OP &&
                 (byte_in & eeprom_pkg::CODE_MASK) == eeprom_pkg::READ_STATUS_CMD) begin
      out_q <= status;
    end else if (fall && state_q == S_DATA &&
                 (op_q == eeprom_pkg::READ_STATUS_CMD || op_q == eeprom_pkg::READ_ARRAY_CMD)) begin
      // drive on falling edge, msb first
      miso_q <= out_q[3'h7 - bit_q];
      miso_oe_q <= 1'b1;
    end
  end

  assign bus.miso = miso_q;
  assign bus.miso_oe = miso_oe_q;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_busy <= 1'b0;
    end else begin
      o_busy <= busy_q;
    end
  end
endmodule

//--- eeprom_link_props.sv
// checker: link-level assertions between the serial master and the memory device
module eeprom_link_props #(
  parameter int SCK_HALF = 12
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic suspend_n,
  input wire logic write_protect_n
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  logic [7:0] edges_q;

  ////////////////////////////////////////////////////////////////////////////
  // rising link clock edges since select fell; only the low bits matter
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn || cs_n) begin
      edges_q <= 8'h00;
    end else if ($rose(sck)) begin
      edges_q <= edges_q + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // eight cycles cover the device's input synchroniser delay
  AST_OE_IDLE: assert property (cs_n [*8] |-> !miso_oe)
    else $error("data out driven while deselected");
  AST_OE_IN_FRAME: assert property ($rose(miso_oe) |-> !cs_n)
    else $error("data out enabled outside a frame");
  AST_CS_FALL: assert property ($fell(cs_n) |-> !sck)
    else $error("select fell with clock high");
  AST_CS_RISE: assert property ($rose(cs_n) |-> !sck && edges_q[2:0] == 3'h0)
    else $error("select rose mid-byte or with clock high");
  AST_SCK_IN_FRAME: assert property (sck |-> !cs_n)
    else $error("link clock high while deselected");
  AST_MOSI_HELD: assert property (sck && $past(sck) |-> $stable(mosi))
    else $error("data in changed while clock high");
  AST_SCK_HIGH: assert property ($rose(sck) |-> ##SCK_HALF $fell(sck))
    else $error("link clock high phase has wrong length");
  AST_SUSPEND: assert property ($changed(suspend_n) |-> !sck && !$past(sck))
    else $error("suspend changed around a clock edge");

  // main scenarios
  COV_FRAME_END: cover property ($rose(cs_n));
  COV_READ_OUT: cover property ($rose(miso_oe));
  COV_SUSPEND: cover property ($fell(suspend_n));
  COV_PROTECT: cover property ($fell(write_protect_n));
endmodule

//--- eeprom_pkg.sv
// package: shared constants for the serial memory device and its controller
package eeprom_pkg;
  localparam int unsigned ADDR_W = 15;
  localparam int unsigned DEPTH = 32768;
  localparam int unsigned PAGE_W = 7;
  // instruction codes, bit 3 sent as zero
  localparam logic [7:0] SET_WRITE_LATCH_CMD = 8'h06;
  localparam logic [7:0] CLEAR_WRITE_LATCH_CMD = 8'h04;
  localparam logic [7:0] READ_STATUS_CMD = 8'h05;
  localparam logic [7:0] WRITE_STATUS_CMD = 8'h01;
  localparam logic [7:0] READ_ARRAY_CMD = 8'h03;
  localparam logic [7:0] WRITE_ARRAY_CMD = 8'h02;
  localparam logic [7:0] CODE_MASK = 8'hf7;
  // status field positions
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_LATCH = 1;
  localparam int unsigned ST_BP_LO = 2;
  localparam int unsigned ST_BP_HI = 4;
  localparam int unsigned ST_PROT_EN = 7;
  // timing
  localparam int unsigned SYS_CLK_HZ = 10_000_000;
  localparam int unsigned WRITE_TIME_US = 5000;
  localparam int unsigned WRITE_CYCLES = WRITE_TIME_US * (SYS_CLK_HZ / 1_000_000);
  // link half period in system cycles; it must outlast the round trip through both synchronisers
  localparam int unsigned SCK_HALF = 12;
  // controller register offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_TXD = 4'h8;
  localparam logic [3:0] REG_RXD = 4'hc;
  localparam int unsigned CTRL_START = 0;
  localparam int unsigned CTRL_HOLD = 1;
  localparam int unsigned CTRL_WP = 2;
  localparam int unsigned CTRL_END = 3;
endpackage

//--- pin_sync.sv
// three-stage synchroniser with agreement filter
module pin_sync #(
  parameter logic INIT = 1'b0
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_pin,
  output logic o_level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  // the first stage feeds only the second
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
    end else begin
      s1_q <= i_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  // a change counts once two later stages agree
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      o_level <= INIT;
    end else if (s2_q == s3_q) begin
      o_level <= s3_q;
    end
  end
endmodule

//--- serial_eeprom_spi_frontend_test.sv
// testbench: controller and memory device joined over the serial link
module serial_eeprom_spi_frontend_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int WCYC = 1200;
  logic i_sys_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_supply_ok = 1'b1;
  logic [3:0] i_addr = 4'h0;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [31:0] o_rdata;
  logic o_busy;
  logic [31:0] seed = 32'h4b932bb2;
  logic [31:0] ctrl_bits = 32'h0;
  logic [7:0] stat_model = 8'h00;
  logic [7:0] mem_model [int];
  logic [7:0] rxq [$];
  int n_mismatch = 0;
  int comparisons = 0;

  spi_if spi_if_inst ();
  eeprom_dev #(.WRITE_CYCLES(WCYC)) eeprom_dev_inst (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
    .i_supply_ok(i_supply_ok), .bus(spi_if_inst.dev), .o_busy(o_busy));
  eeprom_ctrl eeprom_ctrl_inst (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .bus(spi_if_inst.ctrl));
  eeprom_link_props #(.SCK_HALF(eeprom_pkg::SCK_HALF)) eeprom_link_props_inst (.i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn), .cs_n(spi_if_inst.cs_n), .sck(spi_if_inst.sck), .mosi(spi_if_inst.mosi),
    .miso(spi_if_inst.miso), .miso_oe(spi_if_inst.miso_oe), .suspend_n(spi_if_inst.suspend_n),
    .write_protect_n(spi_if_inst.write_protect_n));

  ////////////////////////////////////////////////////////////////////////////
  // 10 MHz system clock
  always #50 i_sys_clk = ~i_sys_clk;

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic chk8(input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic results();
    $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // register port cycles; read data stand only in the cycle after the strobe
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask

  // one byte over the link; select stays low unless last is set
  task automatic xfer(input logic [7:0] b, input logic last);
    logic [31:0] s;
    int n;
    wr(eeprom_pkg::REG_TXD, {24'h0, b});
    wr(eeprom_pkg::REG_CTRL, ctrl_bits | 32'h1 | (32'(last) << eeprom_pkg::CTRL_END));
    n = 0;
    repeat (2) @(posedge i_sys_clk);
    do begin
      rd(eeprom_pkg::REG_STAT, s);
      n++;
    end while ((s[0] !== 1'b0 || s[1] !== 1'b1) && n < 300);
    if (n >= 300) n_mismatch++;
    rd(eeprom_pkg::REG_RXD, s);
    rxq.push_back(s[7:0]);
    // the device sees select high only after its synchroniser, so busy shows late
    if (last) repeat (8) @(posedge i_sys_clk);
  endtask

  // wait out a self-timed write, bounded by its nominal length plus 50 cycles
  task automatic idle();
    int n;
    n = 0;
    while (o_busy !== 1'b0 && n < WCYC + 50) begin
      @(posedge i_sys_clk);
      n++;
    end
    chk1(o_busy, 1'b0);
  endtask

  task automatic send(input logic [7:0] q[$]);
    rxq = {};
    foreach (q[i]) xfer(q[i], i == q.size() - 1);
    idle();
  endtask

  task automatic read_status_cmd();
    send('{eeprom_pkg::READ_STATUS_CMD, 8'h00});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // watchdog: whole run takes about two milliseconds of link traffic and write cycles
  initial begin
    #5_000_000;
    n_mismatch++;
    results();
  end

  // main sequence
  initial begin
    logic [7:0] q[$];
    repeat (6) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    chk1(spi_if_inst.cs_n, 1'b1);
    chk1(spi_if_inst.miso_oe, 1'b0);
    chk1(o_busy, 1'b0);
    read_status_cmd();
    chk8(stat_model, rxq[1]);
    $display("test reset done");
    // opcode bit 3 set: latch still follows set and clear codes
    send('{8'h0e});
    stat_model[1] = 1'b1;
    read_status_cmd();
    chk8(stat_model, rxq[1]);
    send('{8'h0c});
    stat_model[1] = 1'b0;
    read_status_cmd();
    chk8(stat_model, rxq[1]);
    $display("test opcode done");
    // four random bytes from offset 126 wrap inside page 0
    send('{eeprom_pkg::SET_WRITE_LATCH_CMD});
    q = '{eeprom_pkg::WRITE_ARRAY_CMD, 8'h00, 8'h7e};
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      q.push_back(seed[7:0]);
      mem_model[(126 + i) % 128] = seed[7:0];
    end
    rxq = {};
    foreach (q[i]) xfer(q[i], i == q.size() - 1);
    chk1(o_busy, 1'b1);
    xfer(eeprom_pkg::READ_STATUS_CMD, 1'b0);
    xfer(8'h00, 1'b1);
    chk8(8'hff, rxq[rxq.size() - 1]);
    // a latch set while busy must be skipped
    xfer(eeprom_pkg::SET_WRITE_LATCH_CMD, 1'b1);
    idle();
    read_status_cmd();
    chk8(stat_model, rxq[1]);
    seed = xs(seed);
    mem_model[32'h7fff] = seed[7:0];
    send('{eeprom_pkg::SET_WRITE_LATCH_CMD});
    send('{eeprom_pkg::WRITE_ARRAY_CMD, 8'h7f, 8'hff, seed[7:0]});
    $display("test page write done");
    // read across the top of the array back to zero
    send('{eeprom_pkg::READ_ARRAY_CMD, 8'h7f, 8'hff, 8'h00, 8'h00, 8'h00});
    for (int i = 0; i < 3; i++) begin
      chk8(mem_model[(32'h7fff + i) % eeprom_pkg::DEPTH], rxq[3 + i]);
    end
    // suspend between bytes, then resume the same read
    rxq = {};
    q = '{eeprom_pkg::READ_ARRAY_CMD, 8'h00, 8'h7e, 8'h00};
    foreach (q[i]) xfer(q[i], 1'b0);
    ctrl_bits[eeprom_pkg::CTRL_HOLD] = 1'b1;
    wr(eeprom_pkg::REG_CTRL, ctrl_bits);
    repeat (20) @(posedge i_sys_clk);
    ctrl_bits[eeprom_pkg::CTRL_HOLD] = 1'b0;
    wr(eeprom_pkg::REG_CTRL, ctrl_bits);
    repeat (8) @(posedge i_sys_clk);
    xfer(8'h00, 1'b1);
    idle();
    chk8(mem_model[126], rxq[3]);
    chk8(mem_model[127], rxq[4]);
    $display("test read done");
    // status protection under the protect pin, and supply loss
    send('{eeprom_pkg::SET_WRITE_LATCH_CMD});
    send('{eeprom_pkg::WRITE_STATUS_CMD, 8'h84});
    stat_model = 8'h84;
    read_status_cmd();
    chk8(stat_model, rxq[1]);
    ctrl_bits[eeprom_pkg::CTRL_WP] = 1'b1;
    wr(eeprom_pkg::REG_CTRL, ctrl_bits);
    send('{eeprom_pkg::SET_WRITE_LATCH_CMD});
    send('{eeprom_pkg::WRITE_STATUS_CMD, 8'h00});
    read_status_cmd();
    chk8(stat_model, rxq[1]);
    send('{eeprom_pkg::SET_WRITE_LATCH_CMD});
    i_supply_ok <= 1'b0;
    repeat (10) @(posedge i_sys_clk);
    i_supply_ok <= 1'b1;
    repeat (6) @(posedge i_sys_clk);
    read_status_cmd();
    chk8(stat_model, rxq[1]);
    ctrl_bits[eeprom_pkg::CTRL_WP] = 1'b0;
    wr(eeprom_pkg::REG_CTRL, ctrl_bits);
    send('{eeprom_pkg::SET_WRITE_LATCH_CMD});
    send('{eeprom_pkg::WRITE_STATUS_CMD, 8'h00});
    stat_model = 8'h00;
    read_status_cmd();
    chk8(stat_model, rxq[1]);
    $display("test protect done");
    results();
  end
endmodule

//--- spi_if.sv
// interface: serial link between controller and memory device
interface spi_if;
  logic cs_n;
  logic sck;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic suspend_n;
  logic write_protect_n;
  modport ctrl (output cs_n, output sck, output mosi, output suspend_n, output write_protect_n,
                input miso, input miso_oe);
  modport dev (input cs_n, input sck, input mosi, input suspend_n, input write_protect_n,
               output miso, output miso_oe);
endinterface
